// [nfc_tx_params.svh]
// Constants for the transmitter driver configuration block.
// Assumes the host interface presents byte-wide register accesses.
`ifndef NFC_TX_PARAMS_SVH
`define NFC_TX_PARAMS_SVH

`define ADDR_DRIVER_MODE      8'h28
`define ADDR_CARRIER_AMP      8'h29
`define ADDR_TX_MOD_CTRL      8'h2A

`define RESET_DRIVER_MODE     8'h00
`define RESET_CARRIER_AMP     8'h00
`define RESET_TX_MOD_CTRL     8'h00
`define READ_UNMAPPED         8'h00

`define MASK_DRIVER_MODE      8'hCF
`define MASK_CARRIER_AMP      8'hDF
`define MASK_TX_MOD_CTRL      8'hFF

`define STYLE_HIGH_Z          3'h0
`define STYLE_OPEN_DRAIN      3'h1
`define STYLE_PUSH_PULL       3'h2
`define STYLE_FORCE_LOW       3'h4
`define STYLE_FORCE_HIGH      3'h5

`define SRC_NONE              2'h0
`define SRC_ENVELOPE          2'h1
`define SRC_EXTERNAL          2'h2

`define LEVEL_MV_0            11'h064
`define LEVEL_MV_1            11'h0FA
`define LEVEL_MV_2            11'h1F4
`define LEVEL_MV_3            11'h3E8
`define LEVEL_MV_FULL         11'h000

`endif

// [nfc_tx_pkg.sv]
// Types for the transmitter driver configuration block.
// Assumes nfc_tx_params.svh is on the include path.
package nfc_tx_pkg;

    typedef struct packed {
        logic       second_driver_invert;
        logic       first_driver_invert;
        logic [1:0] reserved;
        logic       drive_outputs_on;
        logic [2:0] driver_output_style;
    } driver_mode_type;

    typedef struct packed {
        logic [1:0] carrier_level_reduction;
        logic       reserved;
        logic [4:0] residual_carrier;
    } carrier_amp_type;

    typedef struct packed {
        logic [3:0] overshoot_extension_length;
        logic       full_carrier;
        logic       modulation_invert;
        logic [1:0] modulation_source_select;
    } tx_mod_ctrl_type;

    typedef struct packed {
        logic out;
        logic oe;
    } pin_drive_type;

    typedef enum logic [0:0] {
        OVS_IDLE,
        OVS_EXTEND
    } overshoot_state_type;

endpackage

// [nfc_tx_driver_config.sv]
// Register bank and pin logic for the two antenna transmitter drivers.
// Assumes byte register accesses from the host interface on mclk and
// an envelope generated on mclk; the external input is asynchronous.
//
// What this block does
// - Enable bit turns on both driver pins
// - Bit 7 inverts second driver pin
// - Bit 6 inverts first driver pin
// - Style field picks pin drive; three codes unsupported
// - Level code selects 100/250/500/1000 mV offset
// - Low five bits give residual carrier
// - Full carrier overrides level reduction
// - Invert selected modulation signal
// - Source field selects none, envelope, external
// - Upper nibble sets overshoot extension length
`timescale 1ns/1ps
`include "nfc_tx_params.svh"

module nfc_tx_driver_config
    import nfc_tx_pkg::*;
#(
    parameter int CARRIER_DIV = 2
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rstn,
    // Register access
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    output logic             reg_rvalid,
    // Modulation sources
    input  wire logic        envelope_signal,
    input  wire logic        external_signal_input,
    // Driver pins
    output logic             first_driver_pin_out,
    output logic             first_driver_pin_oe,
    output logic             second_driver_pin_out,
    output logic             second_driver_pin_oe,
    // Analog settings
    output logic      [10:0] carrier_level_reduction_mv,
    output logic             full_carrier,
    output logic      [4:0]  residual_carrier,
    output logic             modulation_active
);

    localparam int DIV_W = (CARRIER_DIV > 1) ? $clog2(CARRIER_DIV) : 1;

    ////////////////////////////////////////////////////////////////////////
    // Register file

    driver_mode_type driver_mode_config;
    carrier_amp_type carrier_amplitude_config;
    tx_mod_ctrl_type transmit_modulation_control;
    driver_mode_type next_driver_mode_config;
    carrier_amp_type next_carrier_amplitude_config;
    tx_mod_ctrl_type next_transmit_modulation_control;
    logic [7:0]      next_reg_rdata;
    logic            next_reg_rvalid;

    always_comb begin
        next_driver_mode_config          = driver_mode_config;
        next_carrier_amplitude_config    = carrier_amplitude_config;
        next_transmit_modulation_control = transmit_modulation_control;
        if (reg_wr) begin
            case (reg_addr)
                `ADDR_DRIVER_MODE: begin
                    next_driver_mode_config = reg_wdata & `MASK_DRIVER_MODE;
                end
                `ADDR_CARRIER_AMP: begin
                    next_carrier_amplitude_config = reg_wdata & `MASK_CARRIER_AMP;
                end
                `ADDR_TX_MOD_CTRL: begin
                    next_transmit_modulation_control = reg_wdata & `MASK_TX_MOD_CTRL;
                end
                default: begin
                end
            endcase
        end
    end

    // Reads see the stored value; reserved bits were masked on write
    always_comb begin
        next_reg_rvalid = reg_rd;
        next_reg_rdata  = reg_rdata;
        if (reg_rd) begin
            case (reg_addr)
                `ADDR_DRIVER_MODE: begin
                    next_reg_rdata = driver_mode_config;
                end
                `ADDR_CARRIER_AMP: begin
                    next_reg_rdata = carrier_amplitude_config;
                end
                `ADDR_TX_MOD_CTRL: begin
                    next_reg_rdata = transmit_modulation_control;
                end
                default: begin
                    next_reg_rdata = `READ_UNMAPPED;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            driver_mode_config          <= `RESET_DRIVER_MODE;
            carrier_amplitude_config    <= `RESET_CARRIER_AMP;
            transmit_modulation_control <= `RESET_TX_MOD_CTRL;
            reg_rdata                   <= `READ_UNMAPPED;
            reg_rvalid                  <= 1'b0;
        end else begin
            driver_mode_config          <= next_driver_mode_config;
            carrier_amplitude_config    <= next_carrier_amplitude_config;
            transmit_modulation_control <= next_transmit_modulation_control;
            reg_rdata                   <= next_reg_rdata;
            reg_rvalid                  <= next_reg_rvalid;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // External input synchroniser

    logic [2:0] ext_sync;
    logic       ext_level;
    logic [2:0] next_ext_sync;
    logic       next_ext_level;

    // Level moves only once the last two stages agree
    always_comb begin
        next_ext_sync  = {ext_sync[1:0], external_signal_input};
        next_ext_level = ext_level;
        if (ext_sync[1] == ext_sync[2]) begin
            next_ext_level = ext_sync[2];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            ext_sync  <= 3'h0;
            ext_level <= 1'b0;
        end else begin
            ext_sync  <= next_ext_sync;
            ext_level <= next_ext_level;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Carrier clock enable

    logic [DIV_W-1:0] div_count;
    logic [DIV_W-1:0] next_div_count;
    logic             carrier_tick;

    // Carrier is not derivable from mclk exactly; divider is an estimate
    always_comb begin
        carrier_tick   = (div_count == DIV_W'(CARRIER_DIV - 1));
        next_div_count = carrier_tick ? '0 : div_count + 1'b1;
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            div_count <= '0;
        end else begin
            div_count <= next_div_count;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Modulation source and overshoot extension

    logic                selected_source;
    logic                mod_raw;
    logic                mod_raw_d;
    logic                next_mod_raw_d;
    overshoot_state_type ovs_state;
    overshoot_state_type next_ovs_state;
    logic [3:0]          ovs_count;
    logic [3:0]          next_ovs_count;
    logic                ovs_start;

    always_comb begin
        case (transmit_modulation_control.modulation_source_select)
            `SRC_ENVELOPE: selected_source = envelope_signal;
            `SRC_EXTERNAL: selected_source = ext_level;
            default:       selected_source = 1'b0;
        endcase
        mod_raw = selected_source ^ transmit_modulation_control.modulation_invert;
    end

    always_comb begin
        // Extension starts in the falling cycle itself, so no gap opens
        ovs_start      = mod_raw_d && !mod_raw && (ovs_state == OVS_IDLE) &&
                         (transmit_modulation_control.overshoot_extension_length != 4'h0);
        next_mod_raw_d = mod_raw;
        next_ovs_state = ovs_state;
        next_ovs_count = ovs_count;
        case (ovs_state)
            OVS_IDLE: begin
                if (ovs_start && !carrier_tick) begin
                    next_ovs_state = OVS_EXTEND;
                    next_ovs_count = transmit_modulation_control.overshoot_extension_length;
                end else if (ovs_start &&
                             transmit_modulation_control.overshoot_extension_length != 4'h1) begin
                    next_ovs_state = OVS_EXTEND;
                    next_ovs_count = transmit_modulation_control.overshoot_extension_length - 4'h1;
                end
            end
            OVS_EXTEND: begin
                if (mod_raw) begin
                    next_ovs_state = OVS_IDLE;
                end else if (carrier_tick) begin
                    next_ovs_count = ovs_count - 4'h1;
                    if (ovs_count == 4'h1) begin
                        next_ovs_state = OVS_IDLE;
                    end
                end
            end
            default: begin
                next_ovs_state = OVS_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            mod_raw_d <= 1'b0;
            ovs_state <= OVS_IDLE;
            ovs_count <= 4'h0;
        end else begin
            mod_raw_d <= next_mod_raw_d;
            ovs_state <= next_ovs_state;
            ovs_count <= next_ovs_count;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Driver pins

    pin_drive_type first_drive;
    pin_drive_type second_drive;
    pin_drive_type next_first_drive;
    pin_drive_type next_second_drive;
    logic          mod_total;
    logic          next_modulation_active;

    function automatic pin_drive_type style_drive(input logic [2:0] style,
                                                  input logic       sig);
        pin_drive_type d;
        d = '{out: 1'b0, oe: 1'b0};
        case (style)
            `STYLE_OPEN_DRAIN: d = '{out: 1'b0, oe: ~sig};
            `STYLE_PUSH_PULL:  d = '{out: sig,  oe: 1'b1};
            `STYLE_FORCE_LOW:  d = '{out: 1'b0, oe: 1'b1};
            `STYLE_FORCE_HIGH: d = '{out: 1'b1, oe: 1'b1};
            default:           d = '{out: 1'b0, oe: 1'b0};
        endcase
        return d;
    endfunction

    always_comb begin
        mod_total              = mod_raw | ovs_start | (ovs_state == OVS_EXTEND);
        next_modulation_active = mod_total;
        next_first_drive       = '{out: 1'b0, oe: 1'b0};
        next_second_drive      = '{out: 1'b0, oe: 1'b0};
        if (driver_mode_config.drive_outputs_on) begin
            next_first_drive = style_drive(driver_mode_config.driver_output_style,
                ~mod_total ^ driver_mode_config.first_driver_invert);
            next_second_drive = style_drive(driver_mode_config.driver_output_style,
                ~mod_total ^ driver_mode_config.second_driver_invert);
        end
        if (!driver_mode_config.drive_outputs_on) begin
            next_modulation_active = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            first_drive       <= '{out: 1'b0, oe: 1'b0};
            second_drive      <= '{out: 1'b0, oe: 1'b0};
            modulation_active <= 1'b0;
        end else begin
            first_drive       <= next_first_drive;
            second_drive      <= next_second_drive;
            modulation_active <= next_modulation_active;
        end
    end

    assign first_driver_pin_out  = first_drive.out;
    assign first_driver_pin_oe   = first_drive.oe;
    assign second_driver_pin_out = second_drive.out;
    assign second_driver_pin_oe  = second_drive.oe;

    ////////////////////////////////////////////////////////////////////////
    // Carrier amplitude settings

    logic [10:0] next_level_mv;

    always_comb begin
        case (carrier_amplitude_config.carrier_level_reduction)
            2'h0:    next_level_mv = `LEVEL_MV_0;
            2'h1:    next_level_mv = `LEVEL_MV_1;
            2'h2:    next_level_mv = `LEVEL_MV_2;
            default: next_level_mv = `LEVEL_MV_3;
        endcase
        if (transmit_modulation_control.full_carrier) begin
            next_level_mv = `LEVEL_MV_FULL;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            carrier_level_reduction_mv <= `LEVEL_MV_0;
            full_carrier               <= 1'b0;
            residual_carrier           <= 5'h00;
        end else begin
            carrier_level_reduction_mv <= next_level_mv;
            full_carrier               <= transmit_modulation_control.full_carrier;
            residual_carrier           <= carrier_amplitude_config.residual_carrier;
        end
    end

endmodule // nfc_tx_driver_config

// [nfc_tx_driver_config_checker.sv]
// Assertions on the driver config block ports.
// Assumes byte writes land in the register on the strobe edge.
`timescale 1ns/1ps
`include "nfc_tx_params.svh"
module nfc_tx_driver_config_checker
    import nfc_tx_pkg::*;
#(
    parameter int CARRIER_DIV = 2
) (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        rstn,
    // Register access
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic        reg_rvalid,
    // Pins and settings
    input wire logic        envelope_signal,
    input wire logic        first_driver_pin_out,
    input wire logic        first_driver_pin_oe,
    input wire logic        second_driver_pin_out,
    input wire logic        second_driver_pin_oe,
    input wire logic [10:0] carrier_level_reduction_mv,
    input wire logic        full_carrier,
    input wire logic [4:0]  residual_carrier,
    input wire logic        modulation_active
);
    driver_mode_type dm;
    carrier_amp_type am;
    tx_mod_ctrl_type tc;
    logic [10:0]     lvl;
    ////////////////////////////////////////////////////////////////////
    // Shadow of the three registers, taken from the write strobes
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            dm <= driver_mode_type'(`RESET_DRIVER_MODE);
            am <= carrier_amp_type'(`RESET_CARRIER_AMP);
            tc <= tx_mod_ctrl_type'(`RESET_TX_MOD_CTRL);
        end else if (reg_wr) begin
            if (reg_addr == `ADDR_DRIVER_MODE)
                dm <= driver_mode_type'(reg_wdata & `MASK_DRIVER_MODE);
            if (reg_addr == `ADDR_CARRIER_AMP)
                am <= carrier_amp_type'(reg_wdata & `MASK_CARRIER_AMP);
            if (reg_addr == `ADDR_TX_MOD_CTRL)
                tc <= tx_mod_ctrl_type'(reg_wdata);
        end
    end
    always_comb begin
        case (am.carrier_level_reduction)
            2'h0: lvl = `LEVEL_MV_0;
            2'h1: lvl = `LEVEL_MV_1;
            2'h2: lvl = `LEVEL_MV_2;
            default: lvl = `LEVEL_MV_3;
        endcase
    end
    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    a_read_amp: assert property (reg_rd && reg_addr == `ADDR_CARRIER_AMP
        |=> reg_rvalid && reg_rdata == $past(am)) else $error("amplitude read wrong");
    a_off_quiet: assert property (!$past(dm.drive_outputs_on)
        |-> !first_driver_pin_oe && !second_driver_pin_oe && !modulation_active)
        else $error("disabled outputs active");
    a_first_invert: assert property ($past(dm.drive_outputs_on && dm.driver_output_style
        == `STYLE_PUSH_PULL) |-> first_driver_pin_oe && first_driver_pin_out ==
        (!modulation_active ^ $past(dm.first_driver_invert))) else $error("first pin wrong");
    a_second_invert: assert property ($past(dm.drive_outputs_on && dm.driver_output_style
        == `STYLE_PUSH_PULL) |-> second_driver_pin_oe && second_driver_pin_out ==
        (!modulation_active ^ $past(dm.second_driver_invert))) else $error("second pin wrong");
    a_style_hiz: assert property ($past(dm.driver_output_style) inside {3'h0, 3'h3, 3'h6, 3'h7}
        |-> !first_driver_pin_oe && !second_driver_pin_oe) else $error("high-z style drives");
    a_force_high: assert property ($past(dm.drive_outputs_on && dm.driver_output_style
        == `STYLE_FORCE_HIGH) |-> first_driver_pin_out && second_driver_pin_out)
        else $error("forced high not high");
    a_level_table: assert property (carrier_level_reduction_mv ==
        ($past(tc.full_carrier) ? `LEVEL_MV_FULL : $past(lvl))) else $error("level wrong");
    a_residual_copy: assert property (residual_carrier == $past(am.residual_carrier))
        else $error("residual wrong");
    a_env_follow: assert property ($past(dm.drive_outputs_on && tc.overshoot_extension_length
        == 4'h0 && tc.modulation_source_select == `SRC_ENVELOPE) |-> modulation_active ==
        ($past(envelope_signal) ^ $past(tc.modulation_invert))) else $error("envelope lost");
endmodule // nfc_tx_driver_config_checker

bind nfc_tx_driver_config nfc_tx_driver_config_checker #(.CARRIER_DIV(CARRIER_DIV)) i_chk (
    .mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .envelope_signal(envelope_signal), .first_driver_pin_out(first_driver_pin_out),
    .first_driver_pin_oe(first_driver_pin_oe), .second_driver_pin_out(second_driver_pin_out),
    .second_driver_pin_oe(second_driver_pin_oe), .full_carrier(full_carrier),
    .carrier_level_reduction_mv(carrier_level_reduction_mv),
    .residual_carrier(residual_carrier), .modulation_active(modulation_active));

// [nfc_tx_driver_config_tb.sv]
// Self-checking bench for the driver config block.
// Assumes the checker file is compiled beside the design.
`timescale 1ns/1ps
`include "nfc_tx_params.svh"
module nfc_tx_driver_config_tb
    import nfc_tx_pkg::*;
;
    logic        mclk, rstn, wr, rd, env, ext;
    logic [7:0]  addr, wdata, rdata;
    logic        rvalid, o1, e1, o2, e2, full, act;
    logic [10:0] mv;
    logic [4:0]  res;
    int          failures, n_checks;

    nfc_tx_driver_config #(.CARRIER_DIV(1)) i_dut (
        .mclk(mclk), .rstn(rstn), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
        .reg_rd(rd), .reg_rdata(rdata), .reg_rvalid(rvalid), .envelope_signal(env),
        .external_signal_input(ext), .first_driver_pin_out(o1), .first_driver_pin_oe(e1),
        .second_driver_pin_out(o2), .second_driver_pin_oe(e2),
        .carrier_level_reduction_mv(mv), .full_carrier(full), .residual_carrier(res),
        .modulation_active(act));
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [10:0] got, input logic [10:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
            failures++;
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // Write lands one edge later, outputs one edge after that
    task automatic set(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        cyc(1);
        wr = 1'b0;
        cyc(1);
    endtask
    task automatic get(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        rd = 1'b1;
        cyc(1);
        rd = 1'b0;
        chk({2'h0, rvalid, rdata}, {3'h1, d});
        // Valid stands one cycle; the gap also keeps strobes apart
        cyc(1);
        chk(rvalid, 11'h0);
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rstn = 1'b0;
        cyc(2);
        rstn = 1'b1;
        get(`ADDR_DRIVER_MODE, `RESET_DRIVER_MODE);
        get(`ADDR_CARRIER_AMP, `RESET_CARRIER_AMP);
        get(`ADDR_TX_MOD_CTRL, `RESET_TX_MOD_CTRL);
        get(8'h2B, `READ_UNMAPPED);
        chk({o1, e1, o2, e2, act, full}, 11'h000);
        chk(mv, `LEVEL_MV_0);
    endtask
    task automatic t_regs();
        set(`ADDR_DRIVER_MODE, 8'hF0);
        set(`ADDR_CARRIER_AMP, 8'hFF);
        set(8'h2B, 8'hFF);
        get(`ADDR_DRIVER_MODE, 8'hC0);
        get(`ADDR_CARRIER_AMP, 8'hDF);
        get(8'h2B, `READ_UNMAPPED);
        chk({e1, e2}, 11'h000);
    endtask
    task automatic t_levels();
        logic [10:0] lv [4] = '{`LEVEL_MV_0, `LEVEL_MV_1, `LEVEL_MV_2, `LEVEL_MV_3};
        for (int c = 0; c < 4; c++) begin
            set(`ADDR_CARRIER_AMP, {c[1:0], 1'b1, 5'(c * 7 + 3)});
            chk(mv, lv[c]);
            chk(res, 11'(c * 7 + 3));
        end
        set(`ADDR_TX_MOD_CTRL, 8'h08);
        chk({full, mv}, {1'b1, `LEVEL_MV_FULL});
        get(`ADDR_CARRIER_AMP, 8'hD8);
        set(`ADDR_TX_MOD_CTRL, 8'h00);
        chk({full, mv}, {1'b0, `LEVEL_MV_3});
    endtask
    task automatic t_styles();
        set(`ADDR_TX_MOD_CTRL, 8'h00);
        for (int s = 0; s < 8; s++) begin
            if (s == 3 || s == 6) continue;
            set(`ADDR_DRIVER_MODE, 8'h08 | 8'(s));
            case (s)
                1: chk({o1, e1, o2, e2}, 11'h0);
                2: chk({o1, e1, o2, e2}, 11'hF);
                4: chk({o1, o2}, 11'h0);
                5: chk({o1, o2}, 11'h3);
                default: chk({e1, e2}, 11'h0);
            endcase
        end
        set(`ADDR_DRIVER_MODE, 8'h8A);
        chk({o1, e1, o2, e2}, 11'hD);
        set(`ADDR_DRIVER_MODE, 8'h4A);
        chk({o1, e1, o2, e2}, 11'h7);
        set(`ADDR_DRIVER_MODE, 8'hC9);
        chk({o1, e1, o2, e2}, 11'h5);
        set(`ADDR_DRIVER_MODE, 8'hC2);
        chk({o1, e1, o2, e2}, 11'h0);
    endtask
    // Entries: control byte, envelope, external, expected modulation
    task automatic t_modulation();
        logic [10:0] tb [10] = '{11'h006, 11'h00F, 11'h00D, 11'h013, 11'h014,
                                 11'h01E, 11'h018, 11'h02C, 11'h02B, 11'h039};
        set(`ADDR_DRIVER_MODE, 8'h0A);
        for (int i = 0; i < 10; i++) begin
            set(`ADDR_TX_MOD_CTRL, tb[i][10:3]);
            env = tb[i][2];
            ext = tb[i][1];
            cyc(7);
            chk({act, o1, o2}, {tb[i][0], !tb[i][0], !tb[i][0]});
        end
        set(`ADDR_DRIVER_MODE, 8'h02);
        chk({act, e1, e2}, 11'h0);
    endtask
    task automatic t_overshoot();
        set(`ADDR_DRIVER_MODE, 8'h0A);
        set(`ADDR_TX_MOD_CTRL, 8'h21);
        env = 1'b1;
        cyc(3);
        env = 1'b0;
        cyc(1);
        chk(act, 11'h1);
        cyc(1);
        chk(act, 11'h1);
        cyc(1);
        chk(act, 11'h0);
        cyc(6);
        chk({act, o1}, 11'h1);
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        if (failures == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // Guard against a hung run
    initial begin
        #5000000;
        failures++;
        print_verdict();
    end
    initial begin
        {rstn, wr, rd, env, ext, addr, wdata} = '0;
        failures = 0;
        n_checks = 0;
        #1;
        t_reset();
        t_regs();
        t_levels();
        t_styles();
        t_modulation();
        t_overshoot();
        t_reset();
        print_verdict();
    end
endmodule // nfc_tx_driver_config_tb
